/* hdl/fcpr_map.svh */
`ifndef FCPR_MAP_SVH
`define FCPR_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define FCPR_OFS_RAW_STATUS 8'h00
`define FCPR_OFS_EN_STATUS 8'h04
`define FCPR_OFS_EN_SET 8'h08
`define FCPR_OFS_EN_CLEAR 8'h0C
`define FCPR_OFS_EOI 8'h10
`define FCPR_OFS_FAULT_ADDR 8'h14
`define FCPR_OFS_FAULT_STATUS 8'h18
`define FCPR_OFS_FAULT_CLEAR 8'h1C
`define FCPR_OFS_PRIO_A 8'h20
`define FCPR_OFS_PRIO_B 8'h24
`define FCPR_OFS_PRIO_C 8'h28

// ==========================================================
// Violation and fault-clear bit positions
`define FCPR_BIT_ADDR_VIOL 1
`define FCPR_BIT_PROT_VIOL 0
`define FCPR_BIT_FAULT_CLEAR 0

// ==========================================================
// Field positions
`define FCPR_ACK_VEC_MSB 7
`define FCPR_ACK_VEC_LSB 0
`define FCPR_FS_XID_MSB 31
`define FCPR_FS_XID_LSB 24
`define FCPR_FS_INIT_MSB 23
`define FCPR_FS_INIT_LSB 16
`define FCPR_FS_PRIV_MSB 12
`define FCPR_FS_PRIV_LSB 9
`define FCPR_FS_TYPE_MSB 5
`define FCPR_FS_TYPE_LSB 0
`define FCPR_PA_DATA_LSB 4
`define FCPR_PA_INSTR_LSB 0
`define FCPR_PB_DMA1_TC0_LSB 16
`define FCPR_PB_DMA0_TC1_LSB 12
`define FCPR_PB_DMA0_TC0_LSB 8
`define FCPR_PC_USB_DMA_LSB 12
`define FCPR_PC_USB_CFG_LSB 8
`define FCPR_PC_ETH_LSB 0

// ==========================================================
// Reset values and writable masks
`define FCPR_RST_PRIO_A 32'h4444_2222
`define FCPR_RST_PRIO_B 32'h4440_0000
`define FCPR_RST_PRIO_C 32'h5460_4404
`define FCPR_WMASK_PRIO_A 32'hFFFF_F777
`define FCPR_WMASK_PRIO_B 32'hFFFF_F777
`define FCPR_WMASK_PRIO_C 32'hFFFF_FFFF

`endif

/* hdl/fcpr_pkg.sv */
package fcpr_pkg;

    // ==========================================================
    // Fault report from the access checker
    typedef struct packed {
        logic valid;
        logic is_addr;
        logic [31:0] addr;
        logic [7:0] xid;
        logic [7:0] initiator;
        logic [3:0] priv;
        logic [5:0] ftype;
    } fcpr_fault_t;

    // ==========================================================
    // Arbitration priorities, 0 highest, 7 lowest
    typedef struct packed {
        logic [2:0] cpu_data;
        logic [2:0] cpu_instr;
        logic [2:0] dma1_tc0_prio;
        logic [2:0] dma0_tc1_prio;
        logic [2:0] dma0_tc0_prio;
        logic [2:0] usb_dma_port_prio;
        logic [2:0] usb_cfg_port_prio;
        logic [2:0] ethernet_mac_port_prio;
    } fcpr_prio_t;

    typedef enum logic [5:0] {
        FCPR_FT_NONE = 6'h00,
        FCPR_FT_USER_EXEC = 6'h01,
        FCPR_FT_USER_WRITE = 6'h02,
        FCPR_FT_USER_READ = 6'h04,
        FCPR_FT_SUP_EXEC = 6'h08,
        FCPR_FT_SUP_WRITE = 6'h10,
        FCPR_FT_SUP_READ = 6'h20
    } fcpr_ftype_t;

endpackage

/* hdl/fcpr_regs.sv */
`timescale 1ns/1ns
`include "fcpr_map.svh"

// Behaviour
// R01 - Enable-clear write bit1 disables address irq, bit0 disables protection irq
// R02 - Zero bits in an enable-clear write leave enables unchanged
// R03 - Enable-clear bits 31..2 read zero
// R04 - Software writes zero to end-of-interrupt after servicing
// R05 - End-of-interrupt write re-arms later interrupt generation
// R06 - End-of-interrupt takes 8-bit vector in 7..0; upper bits read zero
// R07 - Full address of the first faulting transfer is captured
// R08 - Fault status 31..24 holds transfer identifier
// R09 - Fault status 23..16 holds initiator identifier
// R10 - Fault status 12..9 holds privilege id; 15..13 and 8..6 read zero
// R11 - Fault status 5..0 holds one-hot fault type
// R12 - Priority fields are 3 bits, 0 highest, 7 lowest
// R13 - First priority register: data port 6..4, instruction port 2..0
// R14 - Second priority register: transfer controllers at 18..16, 14..12, 10..8
// R15 - Third priority register: usb dma 14..12, usb cfg 10..8, mac 2..0
// R16 - Software writes reserved priority fields back with their defaults
// R17 - Bits 11, 7 and 3 of first two priority registers read zero
// R18 - Raw status set by violation or write one; enabled-status write one clears
// R19 - Violations on the register space raise the interrupt
// R20 - First fault stays captured until the capture is cleared
// R21 - Interrupt high while any raw status bit and its enable are set

module fcpr_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire fcpr_pkg::fcpr_fault_t fault,
    output logic irq,
    output logic irq_pulse,
    output fcpr_pkg::fcpr_prio_t prio
);

    // ==========================================================
    // Decode
    logic wr_raw, wr_en_stat, wr_en_set, wr_en_clr, wr_eoi, wr_fclr;
    logic wr_pa, wr_pb, wr_pc;

    assign wr_raw = reg_wr && (reg_addr == `FCPR_OFS_RAW_STATUS);
    assign wr_en_stat = reg_wr && (reg_addr == `FCPR_OFS_EN_STATUS);
    assign wr_en_set = reg_wr && (reg_addr == `FCPR_OFS_EN_SET);
    assign wr_en_clr = reg_wr && (reg_addr == `FCPR_OFS_EN_CLEAR);
    assign wr_eoi = reg_wr && (reg_addr == `FCPR_OFS_EOI);
    assign wr_fclr = reg_wr && (reg_addr == `FCPR_OFS_FAULT_CLEAR);
    assign wr_pa = reg_wr && (reg_addr == `FCPR_OFS_PRIO_A);
    assign wr_pb = reg_wr && (reg_addr == `FCPR_OFS_PRIO_B);
    assign wr_pc = reg_wr && (reg_addr == `FCPR_OFS_PRIO_C);

    // ==========================================================
    // Violation events
    logic [1:0] hw_event;

    always_comb begin
        hw_event = 2'h0;
        hw_event[`FCPR_BIT_ADDR_VIOL] = fault.valid && fault.is_addr; // [R19]
        hw_event[`FCPR_BIT_PROT_VIOL] = fault.valid && !fault.is_addr; // [R19]
    end

    // ==========================================================
    // Raw status: set beats clear in the same cycle
    logic [1:0] raw_irq_status_ff;
    logic [1:0] nxt_raw_irq_status;

    always_comb begin
        nxt_raw_irq_status = raw_irq_status_ff;
        if (wr_en_stat) begin
            nxt_raw_irq_status = nxt_raw_irq_status & ~reg_wdata[1:0]; // [R18]
        end
        if (wr_raw) begin
            nxt_raw_irq_status = nxt_raw_irq_status | reg_wdata[1:0]; // [R18]
        end
        nxt_raw_irq_status = nxt_raw_irq_status | hw_event; // [R18] [R19]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            raw_irq_status_ff <= 2'h0;
        end else begin
            raw_irq_status_ff <= nxt_raw_irq_status;
        end
    end

    // ==========================================================
    // Interrupt enables
    logic [1:0] irq_enable_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_enable_ff <= 2'h0;
        end else if (wr_en_set) begin
            irq_enable_ff <= irq_enable_ff | reg_wdata[1:0];
        end else if (wr_en_clr) begin
            // Only ones disable; zeros keep the enable
            irq_enable_ff <= irq_enable_ff & ~reg_wdata[1:0]; // [R01] [R02]
        end
    end

    // ==========================================================
    // Interrupt output and end-of-interrupt arming
    logic [1:0] enabled_irq_status;
    logic armed_ff;

    assign enabled_irq_status = raw_irq_status_ff & irq_enable_ff;
    assign irq = |enabled_irq_status; // [R21]
    // One pulse per serviced interrupt; a held level would hide a second fault
    assign irq_pulse = irq && armed_ff; // [R05]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed_ff <= 1'b1;
        end else if (wr_eoi) begin
            armed_ff <= 1'b1; // [R05]
        end else if (irq_pulse) begin
            armed_ff <= 1'b0; // [R05]
        end
    end

    // ==========================================================
    // First-fault capture
    logic captured_ff;
    logic capture;
    logic [31:0] fault_address_ff;
    logic [7:0] xid_ff;
    logic [7:0] initiator_id_ff;
    logic [3:0] privilege_id_ff;
    logic [5:0] ftype_ff;

    assign capture = fault.valid && !captured_ff; // [R20]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            captured_ff <= 1'b0;
        end else if (capture) begin
            captured_ff <= 1'b1; // [R20]
        end else if (wr_fclr && reg_wdata[`FCPR_BIT_FAULT_CLEAR]) begin
            captured_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_address_ff <= 32'h0000_0000;
            xid_ff <= 8'h00;
            initiator_id_ff <= 8'h00;
            privilege_id_ff <= 4'h0;
            ftype_ff <= fcpr_pkg::FCPR_FT_NONE;
        end else if (capture) begin
            fault_address_ff <= fault.addr; // [R07]
            xid_ff <= fault.xid; // [R08]
            initiator_id_ff <= fault.initiator; // [R09]
            privilege_id_ff <= fault.priv; // [R10]
            ftype_ff <= fault.ftype; // [R11]
        end else if (wr_fclr && reg_wdata[`FCPR_BIT_FAULT_CLEAR]) begin
            fault_address_ff <= 32'h0000_0000;
            xid_ff <= 8'h00;
            initiator_id_ff <= 8'h00;
            privilege_id_ff <= 4'h0;
            ftype_ff <= fcpr_pkg::FCPR_FT_NONE;
        end
    end

    logic [31:0] fault_status;

    always_comb begin
        fault_status = 32'h0000_0000; // [R10]
        fault_status[`FCPR_FS_XID_MSB:`FCPR_FS_XID_LSB] = xid_ff; // [R08]
        fault_status[`FCPR_FS_INIT_MSB:`FCPR_FS_INIT_LSB] = initiator_id_ff; // [R09]
        fault_status[`FCPR_FS_PRIV_MSB:`FCPR_FS_PRIV_LSB] = privilege_id_ff; // [R10]
        fault_status[`FCPR_FS_TYPE_MSB:`FCPR_FS_TYPE_LSB] = ftype_ff; // [R11]
    end

    // ==========================================================
    // Master priorities
    logic [31:0] master_priority_a_ff;
    logic [31:0] master_priority_b_ff;
    logic [31:0] master_priority_c_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            master_priority_a_ff <= `FCPR_RST_PRIO_A;
        end else if (wr_pa) begin
            master_priority_a_ff <= reg_wdata & `FCPR_WMASK_PRIO_A; // [R17]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            master_priority_b_ff <= `FCPR_RST_PRIO_B;
        end else if (wr_pb) begin
            master_priority_b_ff <= reg_wdata & `FCPR_WMASK_PRIO_B; // [R17]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            master_priority_c_ff <= `FCPR_RST_PRIO_C;
        end else if (wr_pc) begin
            // Reserved fields are stored as written; software keeps defaults
            master_priority_c_ff <= reg_wdata & `FCPR_WMASK_PRIO_C; // [R16]
        end
    end

    // 3-bit fields, lower value wins arbitration
    assign prio.cpu_data = master_priority_a_ff[`FCPR_PA_DATA_LSB +: 3]; // [R12] [R13]
    assign prio.cpu_instr = master_priority_a_ff[`FCPR_PA_INSTR_LSB +: 3]; // [R13]
    assign prio.dma1_tc0_prio = master_priority_b_ff[`FCPR_PB_DMA1_TC0_LSB +: 3]; // [R14]
    assign prio.dma0_tc1_prio = master_priority_b_ff[`FCPR_PB_DMA0_TC1_LSB +: 3]; // [R14]
    assign prio.dma0_tc0_prio = master_priority_b_ff[`FCPR_PB_DMA0_TC0_LSB +: 3]; // [R14]
    assign prio.usb_dma_port_prio = master_priority_c_ff[`FCPR_PC_USB_DMA_LSB +: 3]; // [R15]
    assign prio.usb_cfg_port_prio = master_priority_c_ff[`FCPR_PC_USB_CFG_LSB +: 3]; // [R15]
    assign prio.ethernet_mac_port_prio = master_priority_c_ff[`FCPR_PC_ETH_LSB +: 3]; // [R15]

    // ==========================================================
    // Read path, data one cycle after the strobe
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (reg_addr)
            `FCPR_OFS_RAW_STATUS: nxt_rdata[1:0] = raw_irq_status_ff;
            `FCPR_OFS_EN_STATUS: nxt_rdata[1:0] = enabled_irq_status;
            `FCPR_OFS_EN_SET: nxt_rdata[1:0] = irq_enable_ff;
            `FCPR_OFS_EN_CLEAR: nxt_rdata[1:0] = irq_enable_ff; // [R03]
            `FCPR_OFS_EOI: nxt_rdata = 32'h0000_0000; // [R06]
            `FCPR_OFS_FAULT_ADDR: nxt_rdata = fault_address_ff; // [R07]
            `FCPR_OFS_FAULT_STATUS: nxt_rdata = fault_status;
            `FCPR_OFS_FAULT_CLEAR: nxt_rdata = 32'h0000_0000;
            `FCPR_OFS_PRIO_A: nxt_rdata = master_priority_a_ff;
            `FCPR_OFS_PRIO_B: nxt_rdata = master_priority_b_ff;
            `FCPR_OFS_PRIO_C: nxt_rdata = master_priority_c_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // fcpr_regs

/* tb/fcpr_regs_properties.sv */
`timescale 1ns/1ns
`include "fcpr_map.svh"
module fcpr_regs_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire fcpr_pkg::fcpr_fault_t fault,
    input wire logic irq,
    input wire logic irq_pulse,
    input wire fcpr_pkg::fcpr_prio_t prio
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // Steps
    sequence s_en_all;
        reg_wr && reg_addr == `FCPR_OFS_EN_SET && reg_wdata[1:0] == 2'h3;
    endsequence
    sequence s_fault;
        fault.valid && !reg_wr;
    endsequence
    // ==========================================
    // Checks
    chk_enclr_upper: assert property (reg_rd && reg_addr == `FCPR_OFS_EN_CLEAR |=> reg_rdata[31:2] == 30'h0)
        else $error("enable clear upper bits not zero");
    chk_eoi_zero: assert property (reg_rd && reg_addr == `FCPR_OFS_EOI |=> reg_rdata == 32'h0)
        else $error("eoi read not zero");
    chk_stat_resv: assert property (reg_rd && reg_addr == `FCPR_OFS_FAULT_STATUS |=>
        reg_rdata[15:13] == 3'h0 && reg_rdata[8:6] == 3'h0) else $error("fault status reserved set");
    chk_prio_resv: assert property (reg_rd && (reg_addr == `FCPR_OFS_PRIO_A || reg_addr == `FCPR_OFS_PRIO_B) |=>
        {reg_rdata[11], reg_rdata[7], reg_rdata[3]} == 3'h0) else $error("priority reserved bit set");
    chk_prio_cpu: assert property (reg_wr && reg_addr == `FCPR_OFS_PRIO_A |=>
        prio.cpu_data == $past(reg_wdata[6:4]) && prio.cpu_instr == $past(reg_wdata[2:0]))
        else $error("cpu priority mismatch");
    chk_prio_mac: assert property (reg_wr && reg_addr == `FCPR_OFS_PRIO_C |=>
        prio.ethernet_mac_port_prio == $past(reg_wdata[2:0]) && prio.usb_cfg_port_prio == $past(reg_wdata[10:8]))
        else $error("port priority mismatch");
    chk_clr_quiet: assert property (reg_wr && reg_addr == `FCPR_OFS_EN_CLEAR && reg_wdata[1:0] == 2'h3 |=> !irq)
        else $error("irq after disabling both");
    chk_fault_irq: assert property (s_en_all ##1 !reg_wr ##1 s_fault |=> irq)
        else $error("fault raised no irq");
    chk_pulse_once: assert property (irq_pulse && !(reg_wr && reg_addr == `FCPR_OFS_EOI) |=> !irq_pulse)
        else $error("pulse repeated without eoi");
    chk_pulse_irq: assert property (irq_pulse |-> irq)
        else $error("pulse without irq");
endmodule // fcpr_regs_checker

bind fcpr_regs fcpr_regs_checker u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault(fault), .irq(irq), .irq_pulse(irq_pulse),
    .prio(prio));

/* tb/fcpr_fault_src.sv */
`timescale 1ns/1ns
module fcpr_fault_src (
    input wire logic clk,
    output fcpr_pkg::fcpr_fault_t fault
);
    initial fault = '0;
    // Fields scrambled after the report so stale values never look held
    task automatic fire(input fcpr_pkg::fcpr_fault_t f, input int dly);
        repeat (dly) @(posedge clk);
        @(posedge clk);
        fault <= f;
        @(posedge clk);
        fault <= {1'b0, ~f[58:0]};
    endtask
endmodule // fcpr_fault_src

/* tb/fault_capture_priority_regs_test.sv */
`timescale 1ns/1ns
`include "fcpr_map.svh"
module fault_capture_priority_regs_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    fcpr_pkg::fcpr_fault_t fault;
    logic irq;
    logic irq_pulse;
    fcpr_pkg::fcpr_prio_t prio;
    logic [31:0] exp_q[$];
    logic rd_seen = 1'b0;
    int failures = 0;
    int check_count = 0;
    int seed = 65786;
    logic [31:0] pa, pb, pc;
    fcpr_pkg::fcpr_fault_t f1, f2;

    always #4 clk = ~clk;

    fcpr_regs DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault(fault), .irq(irq), .irq_pulse(irq_pulse), .prio(prio));
    fcpr_fault_src src (.clk(clk), .fault(fault));

    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic pins(input logic [1:0] e);
        #1;
        chk({30'h0, e}, {30'h0, irq, irq_pulse});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    function automatic fcpr_pkg::fcpr_fault_t mk(input int k);
        mk.valid = 1'b1;
        mk.is_addr = k[0];
        mk.addr = $random(seed);
        {mk.xid, mk.initiator, mk.priv} = 20'($random(seed));
        mk.ftype = 6'h01 << k;
    endfunction
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================
    // Read data monitor, one cycle behind the strobe
    always @(posedge clk) begin
        if (rd_seen) begin
            chk(exp_q.pop_front(), reg_rdata);
        end
        rd_seen <= reg_rd;
    end

    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        end_of_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`FCPR_OFS_PRIO_A, 32'h4444_2222);
        rd(`FCPR_OFS_PRIO_B, 32'h4440_0000);
        rd(`FCPR_OFS_PRIO_C, 32'h5460_4404);
        rd(`FCPR_OFS_FAULT_STATUS, 32'h0);
        chk({8'h0, 3'h2, 3'h2, 9'h0, 3'h4, 3'h4, 3'h4}, {8'h0, prio});
        pa = 32'h4444_2222 & ~32'h77 | $random(seed) & 32'h77;
        pb = 32'h4440_0000 & ~32'h7_7700 | $random(seed) & 32'h7_7700;
        pc = 32'h5460_4404 & ~32'h7707 | $random(seed) & 32'h7707;
        wr(`FCPR_OFS_PRIO_A, pa | 32'h888);
        wr(`FCPR_OFS_PRIO_B, pb);
        wr(`FCPR_OFS_PRIO_C, pc);
        rd(`FCPR_OFS_PRIO_A, pa);
        rd(`FCPR_OFS_PRIO_B, pb);
        rd(`FCPR_OFS_PRIO_C, pc);
        chk({8'h0, pa[6:4], pa[2:0], pb[18:16], pb[14:12], pb[10:8], pc[14:12], pc[10:8], pc[2:0]}, {8'h0, prio});
        // ==========================================
        // Capture: every fault type, a later fault must not overwrite
        wr(`FCPR_OFS_EN_SET, 32'h3);
        for (int k = 0; k < 6; k++) begin
            f1 = mk(k);
            f2 = mk(k + 1);
            src.fire(f1, 0);
            pins(k == 0 ? 2'h3 : 2'h2);
            src.fire(f2, k);
            rd(`FCPR_OFS_FAULT_ADDR, f1.addr);
            rd(`FCPR_OFS_FAULT_STATUS, {f1.xid, f1.initiator, 3'h0, f1.priv, 3'h0, f1.ftype});
            wr(`FCPR_OFS_FAULT_CLEAR, 32'h1);
        end
        rd(`FCPR_OFS_RAW_STATUS, 32'h3);
        wr(`FCPR_OFS_EN_CLEAR, 32'h2);
        wr(`FCPR_OFS_EN_CLEAR, 32'hFFFF_FFFC);
        rd(`FCPR_OFS_EN_CLEAR, 32'h1);
        rd(`FCPR_OFS_EN_STATUS, 32'h1);
        rd(`FCPR_OFS_EN_SET, 32'h1);
        wr(`FCPR_OFS_EN_CLEAR, 32'h3);
        pins(2'h0);
        wr(`FCPR_OFS_EOI, 32'h0);
        rd(`FCPR_OFS_EOI, 32'h0);
        wr(`FCPR_OFS_EN_SET, 32'h3);
        pins(2'h3);
        wr(`FCPR_OFS_EN_STATUS, 32'h3);
        pins(2'h0);
        wr(`FCPR_OFS_RAW_STATUS, 32'h1);
        rd(`FCPR_OFS_RAW_STATUS, 32'h1);
        rd(`FCPR_OFS_FAULT_ADDR, 32'h0);
        wr(8'h40, $random(seed));
        rd(8'h40, 32'h0);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule // fault_capture_priority_regs_test
